// >>> rtl/ssp_map.svh
// Purpose: named widths, depths and reset values of the separate-I/O DDR SRAM port
// Assumes: x18 organisation; for x36 set address width 18 and data width 36
// Notes: definitions only, shared by the package and the design modules
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH

// organisation: one address names one two-word burst
`define SSP_ADDR_W 19
`define SSP_DATA_W 18
`define SSP_LANE_W 9

// write mirror stream
`define SSP_FIFO_DEPTH 16
`define SSP_DROP_CNT_W 16

// reset values of strap synchronisers
`define SSP_DLL_SYNC_RST 2'b11
`define SSP_SINGLE_SYNC_RST 2'b00

// highest clock rate with the dll switched off, in MHz
`define SSP_DLL_OFF_MAX_MHZ 167

`endif

// >>> rtl/ssp_pkg.sv
// Purpose: types of the separate-I/O DDR SRAM port
// Assumes: ssp_map.svh gives the widths
// Notes: commands and mirror records travel as packed structs
package ssp_pkg;
`include "ssp_map.svh"

	// gray order along idle -> read -> write
	typedef enum logic [1:0] {
		SSP_OP_IDLE = 2'h0,
		SSP_OP_READ = 2'h1,
		SSP_OP_WRITE = 2'h3
	} ssp_op_t;

	typedef struct packed {
		ssp_op_t op;
		logic [`SSP_ADDR_W-1:0] addr;
	} ssp_cmd_t;

	typedef struct packed {
		logic [`SSP_ADDR_W-1:0] addr;
		logic [`SSP_DATA_W-1:0] word0;
		logic [`SSP_DATA_W-1:0] word1;
	} ssp_rec_t;

endpackage

// >>> rtl/ssp_fifo.sv
// Purpose: dual-clock fifo with gray-coded pointers
// Assumes: DEPTH is a power of two, at least 4
// Notes: read data is combinational from the store; the reader registers it
`timescale 1ns/1ps
module ssp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// filling side
	input wire logic wr_clk_i,
	input wire logic wr_rst_i,
	input wire logic wr_valid_i,
	output logic wr_ready_o,
	input wire logic [WIDTH-1:0] wr_data_i,
	// draining side
	input wire logic rd_clk_i,
	input wire logic rd_rst_i,
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [WIDTH-1:0] rd_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW:0] wbin, wgray, rgray_q1, rgray_q2;
	logic [AW:0] rbin, rgray, wgray_q1, wgray_q2;

	wire push = wr_valid_i & wr_ready_o;
	wire pop = rd_valid_o & rd_ready_i;
	wire [AW:0] next_wbin = wbin + (AW+1)'(push);
	wire [AW:0] next_wgray = next_wbin ^ (next_wbin >> 1);
	wire [AW:0] next_rbin = rbin + (AW+1)'(pop);
	wire [AW:0] next_rgray = next_rbin ^ (next_rbin >> 1);

	// full when the pointers differ only in the two top gray bits
	assign wr_ready_o = wgray != {~rgray_q2[AW:AW-1], rgray_q2[AW-2:0]};
	assign rd_valid_o = rgray != wgray_q2;
	assign rd_data_o = store[rbin[AW-1:0]];

	always_ff @(posedge wr_clk_i) begin
		if (push) begin
			store[wbin[AW-1:0]] <= wr_data_i;
		end
	end

	always_ff @(posedge wr_clk_i or posedge wr_rst_i) begin
		if (wr_rst_i) begin
			wbin <= '0;
			wgray <= '0;
			rgray_q1 <= '0;
			rgray_q2 <= '0;
		end else begin
			wbin <= next_wbin;
			wgray <= next_wgray;
			rgray_q1 <= rgray;
			rgray_q2 <= rgray_q1;
		end
	end

	always_ff @(posedge rd_clk_i or posedge rd_rst_i) begin
		if (rd_rst_i) begin
			rbin <= '0;
			rgray <= '0;
			wgray_q1 <= '0;
			wgray_q2 <= '0;
		end else begin
			rbin <= next_rbin;
			rgray <= next_rgray;
			wgray_q1 <= wgray;
			wgray_q2 <= wgray_q1;
		end
	end
endmodule

// >>> rtl/ssp_sram_port.sv
// Purpose: pin-level logic of a separate-I/O DDR SRAM with two-word bursts
// Assumes: C/C# at the K rate, within half a cycle of K; straps change only while idle
// Notes: every committed write is also offered on a mirror stream in the core domain, or dropped when the fifo is full and counted until the count saturates
// Functional notes
// - write words taken on K then K#
// - low load strobe defines address and direction
// - every access moves exactly two words
// - byte selects sampled with their word, masked bytes kept
// - each byte select gates one 9-bit lane
// - address sampled on K rise, shared read/write
// - 19/18 address bits, array in two halves
// - address ignored when no access is loaded
// - read words driven on C/C#, or K/K#
// - read outputs float when no read is active
// - direction high reads, low writes
// - output data timed from the C pair
// - accesses start on K rise
// - free-running echo clocks follow output clock
// - dll disable low gives one-cycle latency
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_sram_port #(
	parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
	// core clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// clocks from the controller
	input wire logic k_clk_i,
	input wire logic c_clk_i,
	// address and control
	input wire logic load_strobe_n_i,
	input wire logic rw_i,
	input wire logic [`SSP_ADDR_W-1:0] addr_i,
	// write port
	input wire logic [`SSP_DATA_W-1:0] wdata_i,
	input wire logic [`SSP_DATA_W/`SSP_LANE_W-1:0] byte_write_select_n_i,
	// read port
	output logic [`SSP_DATA_W-1:0] q_o,
	output logic q_oe_n_o,
	output logic echo_clk_o,
	output logic echo_clk_n_o,
	// straps
	input wire logic dll_disable_n_i,
	input wire logic single_clk_i,
	// write mirror, filling side on K
	output logic mirror_space_o,
	// write mirror, core side
	output logic mirror_valid_o,
	output ssp_pkg::ssp_rec_t mirror_rec_o,
	input wire logic mirror_ready_i,
	output logic [`SSP_DROP_CNT_W-1:0] mirror_drop_cnt_o,
	output logic core_dll_on_o
);
	import ssp_pkg::*;

	localparam int LANES = `SSP_DATA_W / `SSP_LANE_W;
	localparam int HALF_DEPTH = 1 << `SSP_ADDR_W;

	// ------------------------------------------------------------------
	// straps, caught on K
	// ------------------------------------------------------------------
	logic [1:0] dll_sync;
	logic [1:0] single_sync;
	logic dll_on;
	logic single_mode;

	always_ff @(posedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dll_sync <= `SSP_DLL_SYNC_RST;
			single_sync <= `SSP_SINGLE_SYNC_RST;
		end else begin
			dll_sync <= {dll_sync[0], dll_disable_n_i};
			single_sync <= {single_sync[0], single_clk_i};
		end
	end

	assign dll_on = dll_sync[1];
	assign single_mode = single_sync[1];

	// ------------------------------------------------------------------
	// load decode on the K rising edge
	// ------------------------------------------------------------------
	ssp_cmd_t cmd;
	ssp_cmd_t next_cmd;
	wire load_seen = ~load_strobe_n_i;

	always_comb begin
		next_cmd.op = SSP_OP_IDLE;
		// unloaded edges keep the old address, pins are ignored
		next_cmd.addr = load_seen ? addr_i : cmd.addr;
		case ({load_seen, rw_i})
			2'h3: begin
				next_cmd.op = SSP_OP_READ;
			end
			2'h2: begin
				next_cmd.op = SSP_OP_WRITE;
			end
			default: begin
				next_cmd.op = SSP_OP_IDLE;
			end
		endcase
	end

	always_ff @(posedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd <= '{op: SSP_OP_IDLE, addr: '0};
		end else begin
			cmd <= next_cmd;
		end
	end

	wire rd_now = cmd.op == SSP_OP_READ;
	wire wr_now = cmd.op == SSP_OP_WRITE;

	// ------------------------------------------------------------------
	// write data capture: word 0 on K, word 1 on K#
	// ------------------------------------------------------------------
	logic [`SSP_DATA_W-1:0] wd0;
	logic [`SSP_DATA_W-1:0] wd1;
	logic [LANES-1:0] bws0_n;
	logic [LANES-1:0] bws1_n;

	always_ff @(posedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd0 <= '0;
			bws0_n <= '1;
		end else if (load_seen && !rw_i) begin
			wd0 <= wdata_i;
			bws0_n <= byte_write_select_n_i;
		end
	end

	// K# rising is the K falling edge of the pair
	always_ff @(negedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd1 <= '0;
			bws1_n <= '1;
		end else if (wr_now) begin
			wd1 <= wdata_i;
			bws1_n <= byte_write_select_n_i;
		end
	end

	// ------------------------------------------------------------------
	// array: two halves, one per word of the burst
	// ------------------------------------------------------------------
	logic [`SSP_DATA_W-1:0] half_even [HALF_DEPTH];
	logic [`SSP_DATA_W-1:0] half_odd [HALF_DEPTH];
	logic [`SSP_DATA_W-1:0] old0;
	logic [`SSP_DATA_W-1:0] old1;
	logic [`SSP_DATA_W-1:0] new0;
	logic [`SSP_DATA_W-1:0] new1;

	assign old0 = half_even[cmd.addr];
	assign old1 = half_odd[cmd.addr];

	// masked lanes keep the stored byte
	for (genvar l = 0; l < LANES; l++) begin : g_lane
		assign new0[l*`SSP_LANE_W +: `SSP_LANE_W] = bws0_n[l] ?
			old0[l*`SSP_LANE_W +: `SSP_LANE_W] : wd0[l*`SSP_LANE_W +: `SSP_LANE_W];
		assign new1[l*`SSP_LANE_W +: `SSP_LANE_W] = bws1_n[l] ?
			old1[l*`SSP_LANE_W +: `SSP_LANE_W] : wd1[l*`SSP_LANE_W +: `SSP_LANE_W];
	end

	// self-timed commit on the K edge after the load, both words at once
	always_ff @(posedge k_clk_i) begin
		if (wr_now) begin
			half_even[cmd.addr] <= new0;
			half_odd[cmd.addr] <= new1;
		end
	end

	// ------------------------------------------------------------------
	// read staging on K
	// ------------------------------------------------------------------
	logic [`SSP_DATA_W-1:0] hold0;
	logic [`SSP_DATA_W-1:0] hold1;
	logic hold_vld;

	always_ff @(posedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold0 <= '0;
			hold1 <= '0;
			hold_vld <= 1'b0;
		end else begin
			hold0 <= old0;
			hold1 <= old1;
			hold_vld <= rd_now;
		end
	end

	// copies taken on K#: a rise of C up to half a cycle after K still sees settled values
	logic [`SSP_DATA_W-1:0] mid0;
	logic [`SSP_DATA_W-1:0] mid1;
	logic mid_rd;
	logic mid_vld;

	always_ff @(negedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mid0 <= '0;
			mid1 <= '0;
			mid_rd <= 1'b0;
			mid_vld <= 1'b0;
		end else begin
			mid0 <= old0;
			mid1 <= hold1;
			mid_rd <= rd_now;
			mid_vld <= hold_vld;
		end
	end

	// ------------------------------------------------------------------
	// output stage on C/C#, or K/K# in single-clock mode
	// ------------------------------------------------------------------
	// a static clock select; switching it live can glitch the output clock
	logic q_clk;
	assign q_clk = single_mode ? k_clk_i : c_clk_i;

	logic [`SSP_DATA_W-1:0] rise_src;
	logic [`SSP_DATA_W-1:0] fall_src;
	logic rise_oe_src;
	logic fall_oe_src;

	// dll on: word 0 on the fall 1.5 cycles on, word 1 on the next rise
	// dll off: word 0 on the next rise, word 1 on the fall after
	assign rise_src = dll_on ? mid1 : mid0;
	assign rise_oe_src = dll_on ? mid_vld : mid_rd;
	assign fall_src = dll_on ? hold0 : hold1;
	assign fall_oe_src = hold_vld;

	logic [`SSP_DATA_W-1:0] q_rise;
	logic [`SSP_DATA_W-1:0] q_fall;
	logic oe_rise;
	logic oe_fall;

	always_ff @(posedge q_clk or posedge rst_i) begin
		if (rst_i) begin
			q_rise <= '0;
			oe_rise <= 1'b0;
		end else begin
			q_rise <= rise_src;
			oe_rise <= rise_oe_src;
		end
	end

	always_ff @(negedge q_clk or posedge rst_i) begin
		if (rst_i) begin
			q_fall <= '0;
			oe_fall <= 1'b0;
		end else begin
			q_fall <= fall_src;
			oe_fall <= fall_oe_src;
		end
	end

	// ddr output mux; enable is low only while a read word stands
	assign q_o = q_clk ? q_rise : q_fall;
	assign q_oe_n_o = ~(q_clk ? oe_rise : oe_fall);

	// echo pair follows the output clock and never stops
	assign echo_clk_o = q_clk;
	assign echo_clk_n_o = ~q_clk;

	// ------------------------------------------------------------------
	// write mirror into the core domain
	// ------------------------------------------------------------------
	ssp_rec_t push_rec;
	ssp_rec_t pop_rec;
	logic fifo_ready;
	logic fifo_valid;
	logic fifo_take;
	logic [`SSP_DROP_CNT_W-1:0] drop_bin;
	logic [`SSP_DROP_CNT_W-1:0] drop_gray;

	assign push_rec = '{addr: cmd.addr, word0: new0, word1: new1};
	assign mirror_space_o = fifo_ready;

	ssp_fifo #(
		.WIDTH($bits(ssp_rec_t)),
		.DEPTH(FIFO_DEPTH)
	) u_mirror_fifo (
		.wr_clk_i(k_clk_i),
		.wr_rst_i(rst_i),
		.wr_valid_i(wr_now),
		.wr_ready_o(fifo_ready),
		.wr_data_i(push_rec),
		.rd_clk_i(core_clk_i),
		.rd_rst_i(rst_i),
		.rd_valid_o(fifo_valid),
		.rd_ready_i(fifo_take),
		.rd_data_o(pop_rec)
	);

	// the sram cannot be stalled, so a record with no room is dropped and counted until the count saturates;
	// the count crosses in gray code, so drops on back-to-back K cycles are not lost
	wire drop_now = wr_now & ~fifo_ready & ~(&drop_bin);
	wire [`SSP_DROP_CNT_W-1:0] next_drop_bin = drop_bin + `SSP_DROP_CNT_W'(drop_now);

	always_ff @(posedge k_clk_i or posedge rst_i) begin
		if (rst_i) begin
			drop_bin <= '0;
			drop_gray <= '0;
		end else begin
			drop_bin <= next_drop_bin;
			drop_gray <= next_drop_bin ^ (next_drop_bin >> 1);
		end
	end

	// core side: one output register, refilled when empty or taken
	assign fifo_take = ~mirror_valid_o | mirror_ready_i;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mirror_valid_o <= 1'b0;
			mirror_rec_o <= '0;
		end else begin
			if (fifo_take) begin
				mirror_valid_o <= fifo_valid;
			end
			if (fifo_take && fifo_valid) begin
				mirror_rec_o <= pop_rec;
			end
		end
	end

	// drop count arrives in gray code through two flops
	logic [`SSP_DROP_CNT_W-1:0] drop_gray_q1;
	logic [`SSP_DROP_CNT_W-1:0] drop_gray_q2;
	logic [`SSP_DROP_CNT_W-1:0] drop_core_bin;
	logic [1:0] dll_core_sync;

	// gray to binary, one prefix xor per bit
	for (genvar i = 0; i < `SSP_DROP_CNT_W; i++) begin : g_drop_bin
		assign drop_core_bin[i] = ^drop_gray_q2[`SSP_DROP_CNT_W-1:i];
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			drop_gray_q1 <= '0;
			drop_gray_q2 <= '0;
			dll_core_sync <= '0;
			mirror_drop_cnt_o <= '0;
		end else begin
			drop_gray_q1 <= drop_gray;
			drop_gray_q2 <= drop_gray_q1;
			dll_core_sync <= {dll_core_sync[0], dll_on};
			mirror_drop_cnt_o <= drop_core_bin;
		end
	end

	assign core_dll_on_o = dll_core_sync[1];
endmodule

// >>> dv/ssp_port_asserts.sv
// Purpose: port checks of the sram port
// Assumes: reads at least four K cycles apart; C lags K
// Notes: oe is sampled on K edges, clear of the C edges
`timescale 1ns/1ps
module ssp_port_asserts (
	// clocks and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic k_clk_i,
	input wire logic c_clk_i,
	// link
	input wire logic load_strobe_n_i,
	input wire logic rw_i,
	input wire logic q_oe_n_o,
	input wire logic echo_clk_o,
	input wire logic echo_clk_n_o,
	// straps
	input wire logic dll_disable_n_i,
	input wire logic single_clk_i,
	input wire logic core_dll_on_o
);
	logic rd_k;
	always_ff @(posedge k_clk_i or posedge rst_i) begin
		if (rst_i) rd_k <= 1'b0;
		else rd_k <= !load_strobe_n_i && rw_i;
	end
	AST_RD_FIRST: assert property (@(negedge k_clk_i) disable iff (rst_i)
		rd_k |-> ##1 (q_oe_n_o == dll_disable_n_i)) else $error("first read word misplaced");
	AST_RD_LAST: assert property (@(negedge k_clk_i) disable iff (rst_i)
		rd_k |-> ##2 (q_oe_n_o == !dll_disable_n_i)) else $error("read end misplaced");
	AST_RD_END: assert property (@(negedge k_clk_i) disable iff (rst_i)
		rd_k |-> ##3 q_oe_n_o) else $error("read longer than two words");
	AST_OE_IDLE: assert property (@(posedge k_clk_i) disable iff (rst_i)
		(load_strobe_n_i || !rw_i) [*3] |-> q_oe_n_o) else $error("output driven without read");
	AST_ECHO_INV: assert property (@(posedge core_clk_i) disable iff (rst_i)
		echo_clk_n_o == !echo_clk_o) else $error("echo pair not inverse");
	AST_ECHO_C: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!single_clk_i [*4] |-> echo_clk_o == c_clk_i) else $error("echo not on C");
	AST_ECHO_K: assert property (@(posedge core_clk_i) disable iff (rst_i)
		single_clk_i [*4] |-> echo_clk_o == k_clk_i) else $error("echo not on K");
	AST_DLL_ON: assert property (@(posedge core_clk_i) disable iff (rst_i)
		dll_disable_n_i [*6] |-> core_dll_on_o) else $error("dll state stale");
	AST_DLL_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i)
		!dll_disable_n_i [*6] |-> !core_dll_on_o) else $error("dll state stale");
	COV_RD_ON: cover property (@(negedge k_clk_i) rd_k && dll_disable_n_i);
	COV_RD_OFF: cover property (@(negedge k_clk_i) rd_k && !dll_disable_n_i);
	COV_RD_K: cover property (@(negedge k_clk_i) rd_k && single_clk_i);
endmodule

bind ssp_sram_port ssp_port_asserts u_ssp_port_asserts (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.k_clk_i(k_clk_i), .c_clk_i(c_clk_i), .load_strobe_n_i(load_strobe_n_i), .rw_i(rw_i),
	.q_oe_n_o(q_oe_n_o), .echo_clk_o(echo_clk_o), .echo_clk_n_o(echo_clk_n_o),
	.dll_disable_n_i(dll_disable_n_i), .single_clk_i(single_clk_i), .core_dll_on_o(core_dll_on_o));

// >>> dv/ssp_ctl_model.sv
// Purpose: controller side of the sram port: clocks, loads and bursts
// Assumes: one access at a time
// Notes: released pins flip each cycle so stale values never pass
`timescale 1ns/1ps
`include "ssp_map.svh"
module ssp_ctl_model (
	// clocks
	output logic k_clk_o,
	output logic c_clk_o,
	// control and write data
	output logic load_strobe_n_o = 1'b1,
	output logic rw_o = 1'b0,
	output logic [`SSP_ADDR_W-1:0] addr_o = '0,
	output logic [`SSP_DATA_W-1:0] wdata_o = '0,
	output logic [1:0] byte_write_select_n_o = '0,
	// read port
	input wire logic [`SSP_DATA_W-1:0] q_i,
	input wire logic q_oe_n_i
);
	logic busy = 1'b0;
	// floating pins show a moving pattern
	wire [`SSP_DATA_W-1:0] q_pin = q_oe_n_i ? {9{k_clk_o, ~k_clk_o}} : q_i;
	initial begin
		k_clk_o = 1'b0;
		#1.3;
		forever #7.5 k_clk_o = ~k_clk_o;
	end
	assign #3 c_clk_o = k_clk_o;
	always @(posedge k_clk_o) begin
		if (!busy) begin
			addr_o <= ~addr_o;
			rw_o <= ~rw_o;
			wdata_o <= ~wdata_o;
			byte_write_select_n_o <= ~byte_write_select_n_o;
		end
	end
	task automatic wr(input logic [18:0] a, input logic [17:0] w0, w1, input logic [1:0] b0, b1);
		busy = 1'b1;
		@(posedge k_clk_o);
		load_strobe_n_o <= 1'b0;
		rw_o <= 1'b0;
		addr_o <= a;
		wdata_o <= w0;
		byte_write_select_n_o <= b0;
		@(posedge k_clk_o);
		load_strobe_n_o <= 1'b1;
		wdata_o <= w1;
		byte_write_select_n_o <= b1;
		@(negedge k_clk_o);
		busy = 1'b0;
	endtask
	task automatic rd(input logic [18:0] a, input int lat, output logic [17:0] q0, q1, output logic [2:0] oe);
		busy = 1'b1;
		@(posedge k_clk_o);
		load_strobe_n_o <= 1'b0;
		rw_o <= 1'b1;
		addr_o <= a;
		@(posedge k_clk_o);
		load_strobe_n_o <= 1'b1;
		busy = 1'b0;
		repeat (lat) @(k_clk_o);
		#3.75 q0 = q_pin;
		oe[0] = q_oe_n_i;
		@(k_clk_o) #3.75 q1 = q_pin;
		oe[1] = q_oe_n_i;
		@(k_clk_o) #3.75 oe[2] = q_oe_n_i;
	endtask
endmodule

// >>> dv/ddr2_sio_sram_port_bench.sv
// Purpose: self-checking bench of the sram port and its write mirror
// Assumes: x18 widths; C lags K by 3 ns
// Notes: dropped mirror records are always the newest ones
`timescale 1ns/1ps
`include "ssp_map.svh"
module ddr2_sio_sram_port_bench;
	import ssp_pkg::*;
	logic core_clk_i;
	logic rst_i = 1'b1;
	logic dll_n = 1'b1;
	logic single = 1'b0;
	logic m_ready = 1'b0;
	logic m_rand = 1'b1;
	wire k_clk, c_clk, ld_n, rw, q_oe_n, echo, echo_n, m_space, m_valid, dll_on;
	wire [`SSP_ADDR_W-1:0] addr;
	wire [`SSP_DATA_W-1:0] wdata, q;
	wire [1:0] byte_write_select_n;
	wire [`SSP_DROP_CNT_W-1:0] drops;
	ssp_rec_t rec;
	int n_errors = 0;
	int samples_checked = 0;
	int n_rx = 0;
	logic [35:0] mem [int];
	ssp_rec_t exp_q[$];
	ssp_ctl_model u_ssp_ctl_model (.k_clk_o(k_clk), .c_clk_o(c_clk), .load_strobe_n_o(ld_n), .rw_o(rw),
		.addr_o(addr), .wdata_o(wdata), .byte_write_select_n_o(byte_write_select_n), .q_i(q), .q_oe_n_i(q_oe_n));
	ssp_sram_port #(.FIFO_DEPTH(16)) u_ssp_sram_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.k_clk_i(k_clk), .c_clk_i(c_clk), .load_strobe_n_i(ld_n), .rw_i(rw), .addr_i(addr),
		.wdata_i(wdata), .byte_write_select_n_i(byte_write_select_n), .q_o(q), .q_oe_n_o(q_oe_n), .echo_clk_o(echo),
		.echo_clk_n_o(echo_n), .dll_disable_n_i(dll_n), .single_clk_i(single), .mirror_space_o(m_space),
		.mirror_valid_o(m_valid), .mirror_rec_o(rec), .mirror_ready_i(m_ready),
		.mirror_drop_cnt_o(drops), .core_dll_on_o(dll_on));
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, e);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cmp_word(input logic [17:0] g, e); chk(g, e); endtask
	task automatic cmp_flag(input logic g, e); chk(g, e); endtask
	task automatic cmp_rec(input ssp_rec_t g, e); chk(g, e); endtask
	task automatic cmp_cnt(input logic [15:0] g, e); chk(g, e); endtask
	function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] b);
		return {b[1] ? o[17:9] : n[17:9], b[0] ? o[8:0] : n[8:0]};
	endfunction
	task automatic wr(input logic [18:0] a, input logic [1:0] b0, b1);
		logic [17:0] w0, w1;
		ssp_rec_t r;
		w0 = 18'($urandom);
		w1 = 18'($urandom);
		if (!mem.exists(a)) mem[a] = 'x;
		r.addr = a;
		r.word0 = mrg(mem[a][17:0], w0, b0);
		r.word1 = mrg(mem[a][35:18], w1, b1);
		mem[a] = {r.word1, r.word0};
		exp_q.push_back(r);
		u_ssp_ctl_model.wr(a, w0, w1, b0, b1);
	endtask
	task automatic rd(input logic [18:0] a);
		logic [17:0] q0, q1;
		logic [2:0] oe;
		u_ssp_ctl_model.rd(a, dll_n ? 3 : 2, q0, q1, oe);
		cmp_word(q0, mem[a][17:0]);
		cmp_word(q1, mem[a][35:18]);
		cmp_cnt(oe, 3'h4);
	endtask
	task automatic phase(input int n);
		logic [18:0] a;
		for (int i = 0; i < n; i++) begin
			a = (i == 0) ? '0 : (i == 1) ? '1 : 19'($urandom);
			wr(a, 2'h0, 2'h0);
			rd(a);
			wr(a, 2'($urandom), 2'($urandom));
			rd(a);
			@(posedge k_clk);
			#1 cmp_flag(echo, single);
			cmp_flag(echo_n, !single);
		end
	endtask
	always @(posedge core_clk_i) begin
		m_ready <= m_rand && ($urandom_range(3) != 0);
		if (m_valid === 1'b1 && m_ready) begin
			n_rx++;
			if (exp_q.size() == 0) cmp_flag(1'b1, 1'b0);
			else cmp_rec(rec, exp_q.pop_front());
		end
	end
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	initial begin
		#200000;
		n_errors++;
		end_of_test();
	end
	initial begin
		int seed;
		int fill_rx;
		seed = $urandom(6968);
		repeat (8) @(posedge core_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		phase(10);
		dll_n <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		phase(4);
		single <= 1'b1;
		dll_n <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		phase(4);
		repeat (300) if (exp_q.size() != 0) @(posedge core_clk_i);
		m_rand <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		fill_rx = n_rx;
		for (int i = 0; i < 20; i++) wr(19'(i), 2'h0, 2'h0);
		repeat (8) @(posedge core_clk_i);
		cmp_flag(m_space, 1'b0);
		m_rand <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		repeat (300) if (m_valid !== 1'b0) @(posedge core_clk_i);
		cmp_cnt(drops, 16'(20 - (n_rx - fill_rx)));
		cmp_flag(n_rx - fill_rx >= 16, 1'b1);
		exp_q.delete();
		end_of_test();
	end
endmodule
